/* scan_tap_pkg.sv */
// shared constants and types for the boundary-scan test port
package scan_tap_pkg;
    // chain sizing
    localparam int NUM_IO_PINS      = 68;
    localparam int NUM_INPUT_PINS   = 4;
    localparam int NUM_MACROCELLS   = 64;
    localparam int IR_WIDTH         = 4;
    localparam int ID_WIDTH         = 32;
    // instruction codes (bypass is all ones)
    localparam logic [3:0] INSTR_EXTEST  = 4'h0;
    localparam logic [3:0] INSTR_SAMPLE  = 4'h1;
    localparam logic [3:0] INSTR_IDCODE  = 4'h2;
    localparam logic [3:0] INSTR_HIGHZ   = 4'h3;
    localparam logic [3:0] INSTR_PROG    = 4'h4;
    localparam logic [3:0] INSTR_BYPASS  = 4'hf;
    // capture pattern loaded into the instruction register
    localparam logic [3:0] IR_CAPTURE    = 4'h1;
    // arbitrary identification value, not a real maker code
    localparam logic [31:0] ID_VALUE_DEF = 32'h0000_0001;
    localparam int PROG_WORD_BITS   = 16;

    typedef enum logic [15:0] {
        ST_RESET     = 16'h0001, ST_IDLE      = 16'h0002,
        ST_SEL_DR    = 16'h0004, ST_CAP_DR    = 16'h0008,
        ST_SHIFT_DR  = 16'h0010, ST_EXIT1_DR  = 16'h0020,
        ST_PAUSE_DR  = 16'h0040, ST_EXIT2_DR  = 16'h0080,
        ST_UPD_DR    = 16'h0100, ST_SEL_IR    = 16'h0200,
        ST_CAP_IR    = 16'h0400, ST_SHIFT_IR  = 16'h0800,
        ST_EXIT1_IR  = 16'h1000, ST_PAUSE_IR  = 16'h2000,
        ST_EXIT2_IR  = 16'h4000, ST_UPD_IR    = 16'h8000
    } tap_state_t;

    // the three test port input pins seen from inside
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } link_in_t;
endpackage

/* scan_tap.sv */
// boundary-scan test access port with pin and macrocell boundary cells
`timescale 1ns/1ps
module scan_tap
    import scan_tap_pkg::*;
#(
    parameter int          IO_PINS  = NUM_IO_PINS,
    parameter int          IN_PINS  = NUM_INPUT_PINS,
    parameter int          MACROS   = NUM_MACROCELLS,
    parameter logic [31:0] ID_VALUE = ID_VALUE_DEF
) (
    // clock and reset (resetn models power-up reset)
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // configuration options
    input  wire logic                          port_enable,
    input  wire logic                          pullup_enable,
    // test port pins
    input  wire link_in_t                      link_in,
    output logic                               tdo_out,
    output logic                               tdo_oe,
    output logic                               tms_pullup,
    output logic                               tdi_pullup,
    // pins and core logic
    input  wire logic [IO_PINS+IN_PINS-1:0]    pin_in,
    input  wire logic [IO_PINS-1:0]            core_out,
    input  wire logic [IO_PINS-1:0]            core_oe,
    output logic [IO_PINS-1:0]                 pin_out,
    output logic [IO_PINS-1:0]                 pin_oe,
    input  wire logic [MACROS-1:0]             macro_in,
    output logic [MACROS-1:0]                  macro_out,
    // programming data path
    output logic [PROG_WORD_BITS-1:0]          prog_data,
    output logic                               prog_strobe,
    // debug state
    output logic                               tap_in_reset
);
    localparam int NPIN  = IO_PINS + IN_PINS;
    // io cell: in capture, out capture, oe capture; input pins: one stage
    localparam int CHAIN = 3 * IO_PINS + IN_PINS + MACROS;

    // two-flop synchronisers for the pins
    link_in_t  sync1_q, sync2_q;
    logic      tck_prev_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= link_in;
            sync2_q    <= sync1_q;
            tck_prev_q <= sync2_q.tck;
        end
    end
    // edge enables; disabled port ignores the pins entirely
    wire tck_rise = port_enable & sync2_q.tck & ~tck_prev_q;
    wire tck_fall = port_enable & ~sync2_q.tck & tck_prev_q;

    function automatic tap_state_t next_state(tap_state_t s, logic m);
        unique case (s)
            ST_RESET:    next_state = m ? ST_RESET   : ST_IDLE;
            ST_IDLE:     next_state = m ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_DR:   next_state = m ? ST_SEL_IR  : ST_CAP_DR;
            ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = m ? ST_UPD_DR  : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = m ? ST_UPD_DR  : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = m ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_IR:   next_state = m ? ST_RESET   : ST_CAP_IR;
            ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = m ? ST_UPD_IR  : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = m ? ST_UPD_IR  : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = m ? ST_SEL_DR  : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    endfunction

    // tap state machine; power-up reset or five tck rises with tms high reach the reset state
    tap_state_t state_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn)
            state_q <= ST_RESET;
        else if (tck_rise)
            state_q <= next_state(state_q, sync2_q.tms);
    end

    // instruction register, reset selects idcode
    logic [IR_WIDTH-1:0] ir_shift_q, ir_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ir_shift_q <= '0;
            ir_q       <= INSTR_IDCODE;
        end else if (tck_rise) begin
            unique case (state_q)
                ST_RESET:    ir_q <= INSTR_IDCODE;
                ST_CAP_IR:   ir_shift_q <= IR_CAPTURE;
                ST_SHIFT_IR: ir_shift_q <= {sync2_q.tdi, ir_shift_q[IR_WIDTH-1:1]};
                default: ;
            endcase
        end else if (tck_fall && state_q == ST_UPD_IR) begin
            ir_q <= ir_shift_q;
        end
    end

    // unknown codes behave as bypass
    wire sel_extest = (ir_q == INSTR_EXTEST);
    wire sel_sample = (ir_q == INSTR_SAMPLE);
    wire sel_id     = (ir_q == INSTR_IDCODE);
    wire sel_highz  = (ir_q == INSTR_HIGHZ);
    wire sel_prog   = (ir_q == INSTR_PROG);
    wire sel_bsr    = sel_extest | sel_sample;
    wire sel_byp    = ~(sel_bsr | sel_id | sel_prog);

    // capture chain: pin cells first, then macrocell cells
    logic [CHAIN-1:0]          bsr_q;
    logic [ID_WIDTH-1:0]       id_q;
    logic                      byp_q;
    logic [PROG_WORD_BITS-1:0] prog_q;
    wire  [CHAIN-1:0] cap_vec = {macro_in, core_oe, core_out, pin_in};
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            bsr_q <= '0;
            id_q  <= '0;
            byp_q <= 1'b0;
            prog_q <= '0;
        end else if (tck_rise) begin
            if (state_q == ST_CAP_DR) begin
                if (sel_bsr)
                    bsr_q <= cap_vec;
                id_q  <= ID_VALUE;
                byp_q <= 1'b0;
            end else if (state_q == ST_SHIFT_DR) begin
                if (sel_bsr)
                    bsr_q <= {sync2_q.tdi, bsr_q[CHAIN-1:1]};
                if (sel_id)
                    id_q <= {sync2_q.tdi, id_q[ID_WIDTH-1:1]};
                if (sel_byp)
                    byp_q <= sync2_q.tdi;
                if (sel_prog)
                    prog_q <= {sync2_q.tdi, prog_q[PROG_WORD_BITS-1:1]};
            end
        end
    end

    // update stages load on the falling test clock in update state
    logic [CHAIN-1:NPIN] upd_q;
    logic                prog_stb_q;
    logic [PROG_WORD_BITS-1:0] prog_data_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            upd_q       <= '0;
            prog_stb_q  <= 1'b0;
            prog_data_q <= '0;
        end else begin
            prog_stb_q <= 1'b0;
            if (tck_fall && state_q == ST_UPD_DR) begin
                if (sel_bsr)
                    upd_q <= bsr_q[CHAIN-1:NPIN];
                if (sel_prog) begin
                    prog_data_q <= prog_q;
                    prog_stb_q  <= 1'b1;
                end
            end
        end
    end

    // serial output mux, launched on the falling test clock
    logic tdo_q, tdo_oe_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            if (state_q == ST_SHIFT_IR)
                tdo_q <= ir_shift_q[0];
            else if (sel_bsr)
                tdo_q <= bsr_q[0];
            else if (sel_id)
                tdo_q <= id_q[0];
            else if (sel_prog)
                tdo_q <= prog_q[0];
            else
                tdo_q <= byp_q;
            tdo_oe_q <= (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
        end else if (!port_enable) begin
            tdo_oe_q <= 1'b0;
        end
    end

    // pin and macrocell outputs: core path unless extest; highz only clears pin_oe
    logic [IO_PINS-1:0] pin_out_q, pin_oe_q;
    logic [MACROS-1:0]  macro_q;
    logic               pu_q, rst_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
            macro_q   <= '0;
            pu_q      <= 1'b0;
            rst_q     <= 1'b1;
        end else begin
            pin_out_q <= sel_extest ? upd_q[NPIN+IO_PINS-1:NPIN] : core_out;
            pin_oe_q  <= sel_highz  ? '0 :
                         sel_extest ? upd_q[NPIN+2*IO_PINS-1:NPIN+IO_PINS] : core_oe;
            macro_q   <= sel_extest ? upd_q[CHAIN-1:NPIN+2*IO_PINS] : macro_in;
            pu_q      <= port_enable & pullup_enable;
            rst_q     <= (state_q == ST_RESET);
        end
    end

    assign tdo_out      = tdo_q;
    assign tdo_oe       = tdo_oe_q;
    assign tms_pullup   = pu_q;
    assign tdi_pullup   = pu_q;
    assign pin_out      = pin_out_q;
    assign pin_oe       = pin_oe_q;
    assign macro_out    = macro_q;
    assign prog_data    = prog_data_q;
    assign prog_strobe  = prog_stb_q;
    assign tap_in_reset = rst_q;
endmodule // scan_tap

/* scan_tap_checker.sv */
// assertion checker for the boundary-scan test port
`timescale 1ns/1ps
module scan_tap_checker
    import scan_tap_pkg::*;
(
    // clock, reset, options and link pins
    input wire logic     sys_clk,
    input wire logic     resetn,
    input wire logic     port_enable,
    input wire logic     pullup_enable,
    input wire link_in_t link_in,
    // observed outputs
    input wire logic     tdo_out,
    input wire logic     tdo_oe,
    input wire logic     tms_pullup,
    input wire logic     tdi_pullup,
    input wire logic     prog_strobe,
    input wire logic     tap_in_reset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // reset cannot disable its own check
    reset_out_a: assert property (disable iff (1'b0)
        !resetn |=> tap_in_reset && !tdo_oe && !tdo_out) else $error("bad reset outputs");
    port_off_a: assert property (!port_enable [*2] |-> !tdo_oe && !prog_strobe)
        else $error("port active while off");
    pullup_a: assert property ($past(resetn) |-> tdi_pullup == tms_pullup &&
        tms_pullup == $past(port_enable && pullup_enable)) else $error("pull-up mismatch");
    strobe_pulse_a: assert property (prog_strobe |=> !prog_strobe)
        else $error("strobe too long");
    prog_place_a: assert property (prog_strobe |-> !tdo_oe && !tap_in_reset)
        else $error("strobe outside update");
    // tck halves last at least four cycles, so two cycles back is inside the same half
    tdo_fall_a: assert property ($changed(tdo_out) |-> !$past(link_in.tck, 2))
        else $error("tdo moved off a fall");
    // the output enable is launched with tdo on the detected fall of tck
    oe_rise_a: assert property ($rose(tdo_oe) |-> !$past(link_in.tck, 2))
        else $error("drive began off a fall");
    oe_reset_a: assert property (tdo_oe |-> !tap_in_reset)
        else $error("drive while in reset");
    // main scenarios reached
    cover property (prog_strobe);
    cover property ($rose(tdo_oe));
    cover property ($fell(tap_in_reset));
endmodule // scan_tap_checker

bind scan_tap scan_tap_checker chk_i (.sys_clk, .resetn, .port_enable, .pullup_enable,
    .link_in, .tdo_out, .tdo_oe, .tms_pullup, .tdi_pullup, .prog_strobe, .tap_in_reset);

/* link_host_model.sv */
// behavioural test controller on the far side of the four-wire link
`timescale 1ns/1ps
module link_host_model
    import scan_tap_pkg::*;
(
    // link pins toward the device
    output link_in_t  link_in,
    input  wire logic tdo_out
);
    // mode and data rest at the pulled-up level
    initial link_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    // one 320 ns clock: drive on the fall, read tdo just before the next fall
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        link_in.tck = 1'b0;
        link_in.tms = tms;
        link_in.tdi = tdi;
        #160 link_in.tck = 1'b1;
        #150 tdo = tdo_out;
        #10;
    endtask
    // idle to shift, n bits lsb first, update, back to idle; tck then stands still
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule // link_host_model

/* scan_tap_tb.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module scan_tap_tb;
    import scan_tap_pkg::*;
    typedef struct packed { logic [3:0] ir; logic [31:0] din, dexp; } row_t;
    localparam logic [71:0] PIN = 72'h96_a5c3_0ff0_1234_5678;
    localparam logic [31:0] BYI = 32'h1234_5679;
    localparam logic [31:0] BYO = {BYI[30:0], 1'b0};
    logic        sys_clk = 1'b0, resetn = 1'b0, port_enable = 1'b1, pullup_enable = 1'b1;
    logic [71:0] pin_in = PIN;
    logic [67:0] core_out = 68'h5_a5a5_0f0f_3c3c_9696, core_oe = 68'hf_00ff_ff00_f0f0_0f0f;
    logic [63:0] macro_in = 64'h0123_4567_89ab_cdef, macro_out;
    logic [67:0] pin_out, pin_oe;
    logic [15:0] prog_data, prog_seen;
    logic [31:0] d;
    logic        tdo_out, tdo_oe, tms_pullup, tdi_pullup, prog_strobe, tap_in_reset;
    link_in_t    link_in;
    int          err_count = 0, n_checks = 0, cycles = 0;
    // each mode but prog, the data shifted in and the bits it must return
    row_t rows [6] = '{'{INSTR_IDCODE, 32'h0, ID_VALUE_DEF},
        '{INSTR_SAMPLE, 32'h0, PIN[31:0]},
        '{INSTR_BYPASS, BYI, BYO},
        '{INSTR_EXTEST, BYI, PIN[31:0]},
        '{INSTR_HIGHZ, BYI, BYO},
        '{4'h7, BYI, BYO}};
    scan_tap dut (.sys_clk, .resetn, .port_enable, .pullup_enable, .link_in, .tdo_out,
        .tdo_oe, .tms_pullup, .tdi_pullup, .pin_in, .core_out, .core_oe, .pin_out, .pin_oe,
        .macro_in, .macro_out, .prog_data, .prog_strobe, .tap_in_reset);
    link_host_model host (.link_in, .tdo_out);
    // 25 mhz system clock
    initial forever #20 sys_clk = ~sys_clk;
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp) err_count++;
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // catch the one-cycle programming strobe; cut a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (prog_strobe === 1'b1) prog_seen <= prog_data;
        if (cycles == 10000) err_count++;
        if (cycles == 10000) print_verdict();
    end
    // reset, table rows, then programming, tms reset and option off
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #13 chk({tap_in_reset, tdo_oe, tms_pullup}, 3'b101);
        host.step(1'b0, 1'b1, d[0]);
        foreach (rows[k]) begin
            host.scan(1'b1, {28'h0, rows[k].ir}, 4, d);
            chk(d[3:0], IR_CAPTURE);
            host.scan(1'b0, rows[k].din, 32, d);
            chk(d, rows[k].dexp);
            if (rows[k].ir == INSTR_HIGHZ) chk(pin_oe, 68'h0);
            // extest drives the updated chain: 32 bits moved past the captured word
            if (rows[k].ir == INSTR_EXTEST) begin
                chk(pin_out, {core_oe[31:0], core_out[67:32]});
                chk(macro_out, {BYI, macro_in[63:32]});
            end
        end
        host.scan(1'b1, {28'h0, INSTR_PROG}, 4, d);
        host.scan(1'b0, 32'h0000_c35a, 16, d);
        chk(prog_seen, 16'hc35a);
        repeat (5) host.step(1'b1, 1'b1, d[0]);
        chk(tap_in_reset, 1'b1);
        host.step(1'b0, 1'b1, d[0]);
        host.scan(1'b0, 32'h0, 32, d);
        chk(d, ID_VALUE_DEF);
        @(posedge sys_clk);
        port_enable <= 1'b0;
        pullup_enable <= 1'b0;
        // keep link edges off the sampling edge of the system clock
        #13;
        host.scan(1'b1, {28'h0, INSTR_BYPASS}, 4, d);
        chk(tdi_pullup, 1'b0);
        @(posedge sys_clk);
        port_enable <= 1'b1;
        #13;
        host.scan(1'b0, 32'h0, 32, d);
        chk(d, ID_VALUE_DEF);
        print_verdict();
    end
endmodule // scan_tap_tb
